// file: src/port_interrupt_status_pkg.sv
// Package for the video port pin interrupt pending block.
// Assumes a 32-bit APB register bus and one register clock.
package port_interrupt_status_pkg;

  // ==========================================================
  // Bus and vector sizes
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFF_PEND_STATUS = 12'h000;
  localparam logic [11:0] OFF_PEND_CLEAR = 12'h004;
  localparam logic [11:0] OFF_GPIO_FLAG = 12'h008;

  // ==========================================================
  // Field positions
  localparam int BIT_CTRL_THREE = 22;
  localparam int BIT_CTRL_TWO = 21;
  localparam int BIT_CTRL_ONE = 20;
  localparam int BIT_DATA_HI = 19;
  localparam int BIT_DATA_LO = 2;
  localparam int BIT_GPIO_FLAG = 0;

  // Bits that carry a pin; 31..23 and 1..0 read as zero
  localparam logic [31:0] PIN_VALID_MASK = 32'h007ffffc;

  // ==========================================================
  // Reset values
  localparam logic [31:0] RST_PEND_STATUS = 32'h00000000;
  localparam logic [31:0] RST_CLEAR_READ = 32'h00000000;
  localparam logic RST_GPIO_FLAG = 1'b0;

  // Polarity encoding: 0 rising, 1 falling
  localparam logic EDGE_RISING = 1'b0;
  // Direction encoding: 0 input, 1 output
  localparam logic DIR_INPUT = 1'b0;

  // Pin configuration from the neighbouring register blocks
  typedef struct packed {
    logic [31:0] irq_enable;
    logic [31:0] edge_select;
    logic [31:0] function_gpio;
    logic [31:0] direction;
  } port_interrupt_status_pin_cfg_t;

endpackage : port_interrupt_status_pkg

// file: src/port_interrupt_status_pin_sync.sv
// Pin synchroniser and edge detector, one slice per pin bit.
// Assumes asynchronous pins; the edge select comes from the mclk domain.
`timescale 1ns/1ps
module port_interrupt_status_pin_sync #(
  parameter int WIDTH = 32
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_async,
  input wire logic [WIDTH-1:0] edge_select,
  output logic [WIDTH-1:0] edge_hit
);

  // ==========================================================
  // Arming
  // No edge is reported until the chain holds real pin samples,
  // otherwise a pin that is high at reset looks like a rising edge.
  logic [2:0] arm;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      arm <= 3'h0;
    end else begin
      arm <= {arm[1:0], 1'b1};
    end
  end

  // ==========================================================
  // Per-pin chain
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1) begin : g_pin
      logic meta;
      logic stable;
      logic prev;

      always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
          meta <= 1'b0;
          stable <= 1'b0;
          prev <= 1'b0;
        end else begin
          meta <= pin_async[g];
          stable <= meta;
          prev <= stable;
        end
      end

      // R16 current versus previous
      // R2 polarity picks one edge
      always_comb begin
        if (edge_select[g] == port_interrupt_status_pkg::EDGE_RISING) begin
          edge_hit[g] = arm[2] & stable & ~prev;
        end else begin
          edge_hit[g] = arm[2] & ~stable & prev;
        end
      end
    end
  endgenerate

endmodule : port_interrupt_status_pin_sync

// file: src/port_interrupt_status_apb_slave.sv
// APB slave handshake: one wait state, registered answer.
// Assumes the owner supplies read data and an address-valid flag.
`timescale 1ns/1ps
module port_interrupt_status_apb_slave (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] rd_data,
  input wire logic addr_ok,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic wr_commit
);

  // ==========================================================
  // Access phase
  // The answer is registered so every bus output comes from a flop;
  // costs one wait state per transfer.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel & penable & ~pready) begin
      prdata <= pwrite ? 32'h00000000 : rd_data;
      pslverr <= ~addr_ok;
    end else begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end
  end

  // Writes land only on the edge that samples pready high
  assign wr_commit = psel & penable & pready & pwrite & ~pslverr;

endmodule : port_interrupt_status_apb_slave

// file: src/port_interrupt_status_pin_irq.sv
// Video port pin interrupt pending logic with its APB registers.
// Assumes pin configuration arrives from other register blocks on mclk,
// and the port-level interrupt status logic takes gpio_flag.
//
// Operation
// R1 - Pending sets only if enabled, GPIO function and input direction.
// R2 - Pending sets on the edge chosen by polarity, not the other.
// R3 - Any pending bit becoming one sets the port GPIO flag.
// R4 - Writing one to a clear bit clears that pending bit.
// R5 - Writing zero to a clear bit leaves that pending bit alone.
// R6 - Clearing all pending bits leaves the GPIO flag set.
// R7 - Clearing the flag while pending bits remain sets it again.
// R8 - Reading the clear register returns all zeros.
// R9 - Status register is read-only; writes never change pending bits.
// R10 - Bits 22, 21, 20 map to control pins three, two, one.
// R11 - Bits 19 down to 2 map to data pins of same index.
// R12 - Bits 31 to 23 read zero and ignore writes.
// R13 - Clear register is write-only alias with same bit positions.
// R14 - Polarity zero selects rising, one selects falling edge.
// R15 - Enable one allows pin interrupt; reset value zero blocks it.
// R16 - Pins are synchronised and edges found from current versus previous.
// R17 - Edge and clear on the same bit together leave it set.
// R18 - All pending bits reset to zero.
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module port_interrupt_status_pin_irq (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [port_interrupt_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  input wire logic control_pin_one,
  input wire logic control_pin_two,
  input wire logic control_pin_three,
  input wire logic [port_interrupt_status_pkg::BIT_DATA_HI:port_interrupt_status_pkg::BIT_DATA_LO] video_data_pin,
  input wire port_interrupt_status_pkg::port_interrupt_status_pin_cfg_t pin_cfg,
  output logic [31:0] pin_irq_pending_status,
  output logic gpio_flag
);

  // ==========================================================
  // Pin vector
  logic [31:0] pin_vec;
  logic [31:0] edge_hit;
  logic [31:0] qualify;
  logic [31:0] set_vec;

  // R10 control pin bits
  // R11 data pin bits
  always_comb begin
    pin_vec = 32'h00000000;
    pin_vec[port_interrupt_status_pkg::BIT_CTRL_THREE] = control_pin_three;
    pin_vec[port_interrupt_status_pkg::BIT_CTRL_TWO] = control_pin_two;
    pin_vec[port_interrupt_status_pkg::BIT_CTRL_ONE] = control_pin_one;
    pin_vec[port_interrupt_status_pkg::BIT_DATA_HI:port_interrupt_status_pkg::BIT_DATA_LO] = video_data_pin;
  end

  // R16 sync and edge
  // R14 polarity encoding
  port_interrupt_status_pin_sync #(
    .WIDTH(32)
  ) u_sync (
    .mclk(mclk),
    .rst(rst),
    .pin_async(pin_vec),
    .edge_select(pin_cfg.edge_select),
    .edge_hit(edge_hit)
  );

  // R1 three-way qualify
  // R15 enable gates pin
  assign qualify = pin_cfg.irq_enable & pin_cfg.function_gpio &
    ~pin_cfg.direction;
  // R12 reserved bits never set
  assign set_vec = edge_hit & qualify & port_interrupt_status_pkg::PIN_VALID_MASK;

  // ==========================================================
  // Bus decode
  logic wr_commit;
  logic addr_ok;
  logic [31:0] rd_data;
  logic clr_wr;
  logic flag_clr_wr;
  logic [31:0] clr_mask;

  assign addr_ok = (paddr == port_interrupt_status_pkg::OFF_PEND_STATUS) |
    (paddr == port_interrupt_status_pkg::OFF_PEND_CLEAR) |
    (paddr == port_interrupt_status_pkg::OFF_GPIO_FLAG);

  always_comb begin
    rd_data = 32'h00000000;
    case (paddr)
      port_interrupt_status_pkg::OFF_PEND_STATUS: rd_data = pin_irq_pending_status;
      // R8 alias reads zero
      port_interrupt_status_pkg::OFF_PEND_CLEAR: rd_data = port_interrupt_status_pkg::RST_CLEAR_READ;
      port_interrupt_status_pkg::OFF_GPIO_FLAG: begin
        rd_data[port_interrupt_status_pkg::BIT_GPIO_FLAG] = gpio_flag;
      end
      default: rd_data = 32'h00000000;
    endcase
  end

  port_interrupt_status_apb_slave u_apb (
    .mclk(mclk),
    .rst(rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .rd_data(rd_data),
    .addr_ok(addr_ok),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .wr_commit(wr_commit)
  );

  // R13 write-only alias
  // R9 status offset has no write path
  assign clr_wr = wr_commit & (paddr == port_interrupt_status_pkg::OFF_PEND_CLEAR);
  // R4 ones clear
  // R5 zeros ignored
  // R12 upper bits dropped
  assign clr_mask = clr_wr ? (pwdata & port_interrupt_status_pkg::PIN_VALID_MASK) :
    32'h00000000;
  assign flag_clr_wr = wr_commit & (paddr == port_interrupt_status_pkg::OFF_GPIO_FLAG) &
    pwdata[port_interrupt_status_pkg::BIT_GPIO_FLAG];

  // ==========================================================
  // Pending bits
  logic [31:0] next_pending;

  // R17 set beats clear
  assign next_pending = (pin_irq_pending_status & ~clr_mask) | set_vec;

  // R18 reset to zero
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pin_irq_pending_status <= port_interrupt_status_pkg::RST_PEND_STATUS;
    end else begin
      pin_irq_pending_status <= next_pending;
    end
  end

  // ==========================================================
  // Port GPIO flag
  // Level on the pending vector, so a cleared flag returns at once
  // while any pending bit is still standing.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      gpio_flag <= port_interrupt_status_pkg::RST_GPIO_FLAG;
    end else begin
      // R3 set from pending
      // R6 only software clears
      // R7 set again while pending
      gpio_flag <= (gpio_flag & ~flag_clr_wr) |
        (|pin_irq_pending_status) | (|set_vec);
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  logic rd_done;
  assign rd_done = psel & penable & pready & ~pwrite;

  a_pend_needs_qual: assert property ( // R1
    ((pin_irq_pending_status & ~$past(pin_irq_pending_status)) &
      ~$past(qualify)) == 32'h00000000)
    else $error("pending bit set on an unqualified pin");

  a_pend_takes_edge: assert property ( // R2
    (|set_vec) |=> ((pin_irq_pending_status & $past(set_vec)) ==
      $past(set_vec)))
    else $error("detected edge did not set pending");

  a_flag_follows_pend: assert property ( // R3
    (|pin_irq_pending_status) |=> gpio_flag)
    else $error("pending bit without gpio flag");

  a_clear_ones: assert property ( // R4
    clr_wr |=> ((pin_irq_pending_status &
      $past(clr_mask & ~set_vec)) == 32'h00000000))
    else $error("clear write left pending bit set");

  a_clear_zeros: assert property ( // R5
    clr_wr |=> (($past(pin_irq_pending_status) & ~$past(clr_mask) &
      ~pin_irq_pending_status) == 32'h00000000))
    else $error("clear write dropped an unselected bit");

  a_flag_sticky: assert property ( // R6
    (gpio_flag && !flag_clr_wr) |=> gpio_flag)
    else $error("gpio flag fell without a clear");

  a_flag_reassert: assert property ( // R7
    (flag_clr_wr && (|pin_irq_pending_status)) |=> gpio_flag)
    else $error("gpio flag not set again");

  a_alias_read_zero: assert property ( // R8
    (psel && penable && !pready && !pwrite &&
      paddr == port_interrupt_status_pkg::OFF_PEND_CLEAR) |=> (prdata == 32'h00000000))
    else $error("clear register read not zero");

  a_status_read_only: assert property ( // R9
    (wr_commit && paddr == port_interrupt_status_pkg::OFF_PEND_STATUS) |=>
      (($past(pin_irq_pending_status) & ~pin_irq_pending_status) ==
        32'h00000000))
    else $error("status write changed pending");

  a_resv_bits_zero: assert property ( // R12
    (pin_irq_pending_status & ~port_interrupt_status_pkg::PIN_VALID_MASK) == 32'h00000000)
    else $error("reserved pending bit set");

  a_set_beats_clear: assert property ( // R17
    (|(set_vec & clr_mask)) |=>
      ((pin_irq_pending_status & $past(set_vec)) == $past(set_vec)))
    else $error("edge lost under clear");

  c_pin_pending: cover property (
    (|set_vec) ##1 gpio_flag);

  c_clear_then_reassert: cover property (
    flag_clr_wr && (|pin_irq_pending_status) ##1 gpio_flag);

  c_clear_collision: cover property (
    |(set_vec & clr_mask));

  c_status_read: cover property (
    rd_done && paddr == port_interrupt_status_pkg::OFF_PEND_STATUS &&
      prdata != 32'h00000000);

  c_flag_cleared: cover property (
    flag_clr_wr ##1 !gpio_flag);

  // A newly pending bit looks back through the sync pair, the compare
  // flop and the pending flop: its pin edge sits 3 and 4 samples back.
  logic [2:0] ctrl_pins;
  logic [2:0] ctrl_pend;
  logic [port_interrupt_status_pkg::BIT_DATA_HI:port_interrupt_status_pkg::BIT_DATA_LO] data_pend;

  assign ctrl_pins = {control_pin_three, control_pin_two, control_pin_one};
  assign ctrl_pend = pin_irq_pending_status[port_interrupt_status_pkg::BIT_CTRL_THREE:
    port_interrupt_status_pkg::BIT_CTRL_ONE];
  assign data_pend = pin_irq_pending_status[port_interrupt_status_pkg::BIT_DATA_HI:
    port_interrupt_status_pkg::BIT_DATA_LO];

  a_edge_polarity: assert property ( // R14
    ((pin_irq_pending_status & ~$past(pin_irq_pending_status)) &
      ~(($past(pin_vec, 3) & ~$past(pin_vec, 4) &
        ~$past(pin_cfg.edge_select)) |
        (~$past(pin_vec, 3) & $past(pin_vec, 4) &
        $past(pin_cfg.edge_select)))) == 32'h00000000)
    else $error("pending set on the wrong pin edge");

  a_ctrl_pin_map: assert property ( // R10
    ((ctrl_pend & ~$past(ctrl_pend)) &
      ~($past(ctrl_pins, 3) ^ $past(ctrl_pins, 4))) == 3'h0)
    else $error("control pending without a change on its pin");

  a_data_pin_map: assert property ( // R11
    ((data_pend & ~$past(data_pend)) &
      ~($past(video_data_pin, 3) ^ $past(video_data_pin, 4))) == 18'h0)
    else $error("data pending without a change on its pin");

  a_flag_clears: assert property ( // R6
    (flag_clr_wr && !(|pin_irq_pending_status) && !(|set_vec)) |=>
      !gpio_flag)
    else $error("explicit flag clear ignored");

  a_refused_write: assert property ( // R9
    (psel && penable && pready && pwrite && pslverr) |=>
      (($past(pin_irq_pending_status) & ~pin_irq_pending_status) ==
        32'h00000000))
    else $error("refused write changed pending");

  a_status_readback: assert property (
    (psel && penable && !pready && !pwrite &&
      paddr == port_interrupt_status_pkg::OFF_PEND_STATUS) |=>
      (prdata == $past(pin_irq_pending_status)))
    else $error("status read data wrong");

  a_flag_readback: assert property (
    (psel && penable && !pready && !pwrite &&
      paddr == port_interrupt_status_pkg::OFF_GPIO_FLAG) |=>
      (prdata == {31'h0, $past(gpio_flag)}))
    else $error("flag read data wrong");

  // ==========================================================
  // Bus answer checks
  // Registered answer: one wait state, then a single-cycle pulse.
  a_ready_wait: assert property (
    (psel && penable && !pready) |=> pready)
    else $error("access phase got no ready");

  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  a_rdata_idle: assert property (
    !pready |-> (prdata == 32'h00000000))
    else $error("read data driven outside the answer cycle");

  a_slverr_unmapped: assert property (
    (psel && penable && !pready && !addr_ok) |=> (pready && pslverr))
    else $error("unmapped access not flagged");

endmodule : port_interrupt_status_pin_irq

// file: testbench/port_interrupt_status_pin_drv.sv
// Far-side model: external logic that drives the control and data pins.
// Assumes the bench hands it a 32-bit level in pending-bit positions.
`timescale 1ns/1ps
module port_interrupt_status_pin_drv (
  input wire logic mclk,
  input wire logic [31:0] want,
  input wire logic slow,
  output logic control_pin_one,
  output logic control_pin_two,
  output logic control_pin_three,
  output logic [19:2] video_data_pin
);
  logic [31:0] lvl = 32'h0;
  logic [31:0] d1 = 32'h0;
  logic [31:0] d2 = 32'h0;

  // ==========================================================
  // Pin levels
  // Slow mode lags three cycles; only switch it while want is steady
  always @(posedge mclk) begin
    d1 <= want;
    d2 <= d1;
    lvl <= slow ? d2 : want;
  end

  assign control_pin_one = lvl[20];
  assign control_pin_two = lvl[21];
  assign control_pin_three = lvl[22];
  assign video_data_pin = lvl[19:2];
endmodule : port_interrupt_status_pin_drv

// file: testbench/testbench.sv
// Self-checking bench for the pin interrupt pending block.
// Assumes the APB slave answers with pready and the pin driver model.
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'h0;
  logic rst = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic pready, pslverr, gpio_flag, c1, c2, c3, err, slow = 1'h0;
  logic [31:0] prdata, pend_out, rd, want = 32'h0;
  logic [19:2] vd;
  port_interrupt_status_pkg::port_interrupt_status_pin_cfg_t cfg = '0;
  int n_errors = 0;
  int tests_run = 0;
  int seed = 32'h031b;
  int cycles = 0;
  logic [31:0] pend = 32'h0;
  logic [31:0] pins = 32'h0;
  logic flag = 1'h0;

  always #4 mclk = ~mclk;

  port_interrupt_status_pin_irq DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .control_pin_one(c1),
    .control_pin_two(c2), .control_pin_three(c3), .video_data_pin(vd),
    .pin_cfg(cfg), .pin_irq_pending_status(pend_out),
    .gpio_flag(gpio_flag));

  port_interrupt_status_pin_drv drv (.mclk(mclk), .want(want), .slow(slow),
    .control_pin_one(c1), .control_pin_two(c2), .control_pin_three(c3),
    .video_data_pin(vd));

  // ==========================================================
  // Checking and bus tasks
  task report_and_stop;
    $display("compares %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  // Request held until pready is seen high at a rising edge
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do @(posedge mclk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'h0, a, 32'h0);
    chk(what, exp, rd);
    chk("slverr", {31'h0, a > 12'h008}, {31'h0, err});
  endtask : rd_chk

  task check_state;
    // Let a write that landed on the last edge show first
    @(posedge mclk);
    chk("pending", pend, pend_out);
    chk("flag", {31'h0, flag}, {31'h0, gpio_flag});
    rd_chk(12'h000, pend, "status read");
    rd_chk(12'h004, 32'h0, "clear read");
    rd_chk(12'h008, {31'h0, flag}, "flag read");
  endtask : check_state

  // One random pin move under a random configuration; with all_on only edge_select is random and every pin is enabled
  task pin_step(input logic all_on);
    logic [31:0] nw, en, hit;
    slow <= 1'($random(seed));
    cfg <= all_on ? {32'hffffffff, 32'($random(seed)), 32'hffffffff, 32'h0}
      : {32'($random(seed)), 32'($random(seed)), 32'($random(seed)),
         32'($random(seed))};
    repeat (2) @(posedge mclk);
    nw = $random(seed);
    // enable, function and input direction gate the event
    en = cfg.irq_enable & cfg.function_gpio & ~cfg.direction;
    // edge_select 0 rising, 1 falling; same positions
    hit = ((~pins & nw & ~cfg.edge_select) | (pins & ~nw & cfg.edge_select))
      & en & port_interrupt_status_pkg::PIN_VALID_MASK;
    want <= nw;
    pins = nw;
    repeat (12) @(posedge mclk);
    pend = pend | hit;
    if (hit != 32'h0)
      flag = 1'h1;
    chk("pending", pend, pend_out);
    chk("flag", {31'h0, flag}, {31'h0, gpio_flag});
  endtask : pin_step

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] w;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    repeat (5) @(posedge mclk);
    check_state;
    $display("test reset done");
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 10; i++)
        pin_step(i < 3);
      check_state;
      $display("test pins done");
      apb(1'h1, 12'h000, 32'hffffffff);
      @(posedge mclk);
      chk("status write", pend, pend_out);
      apb(1'h1, 12'h00c, 32'hffffffff);
      @(posedge mclk);
      chk("unmapped write", pend, pend_out);
      chk("write slverr", 32'h1, {31'h0, err});
      apb(1'h1, 12'h008, 32'h1);
      // flag comes back while bits are pending
      if (pend == 32'h0)
        flag = 1'h0;
      check_state;
      w = $random(seed);
      apb(1'h1, 12'h004, w);
      pend = pend & ~w;
      check_state;
      apb(1'h1, 12'h004, 32'hffffffff);
      pend = 32'h0;
      check_state;
      apb(1'h1, 12'h008, 32'h1);
      flag = 1'h0;
      check_state;
      rd_chk(12'h00c, 32'h0, "unmapped read");
      $display("test clear done");
    end
    // Reset in mid-run with bits pending and pins left high
    for (int i = 0; i < 3; i++)
      pin_step(1'h1);
    rst <= 1'h1;
    repeat (3) @(posedge mclk);
    rst <= 1'h0;
    pend = 32'h0;
    flag = 1'h0;
    check_state;
    $display("test mid-run reset done");
    report_and_stop;
  end
endmodule : testbench
